/* File: spi_master_slave_core.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_core
  import spi_core_pkg::*;
#(
  parameter int DATA_BITS = WORD_BITS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic enable,
  input wire logic master_select,
  input wire logic clock_polarity,
  input wire logic clock_phase_select,
  input wire logic rate_sel_hi,
  input wire logic rate_sel_lo,
  input wire logic rx_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic err_irq_enable,
  // Software access
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic data_write,
  input wire logic status_read,
  input wire logic data_read,
  output logic [DATA_BITS-1:0] serial_data_reg,
  // Status
  output logic tx_empty_flag,
  output logic rx_full_flag,
  output logic overflow_flag,
  output logic mode_fault_flag,
  output logic busy,
  // Interrupt requests
  output logic rx_full_irq,
  output logic tx_empty_irq,
  output logic error_irq,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Data pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // Slave select
  input wire logic slave_select_n
);

  localparam int EDGES = DATA_BITS * EDGES_PER_BIT;
  localparam int CW = $clog2(EDGES);
  localparam logic [CW-1:0] LAST_EDGE = CW'(EDGES - 1);

  if (DATA_BITS != WORD_BITS)
  begin : gen_width_check
    $error("spi_master_slave_core: only 8-bit transfers are supported");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  xfer_state_t state;
  logic [CW-1:0] edge_count;
  logic [DATA_BITS-1:0] shifter;
  logic [DATA_BITS-1:0] tx_buffer;
  logic tx_full;
  logic shifter_loaded;
  logic out_bit;
  logic sck_level;
  logic sck_prev;
  logic select_prev;
  logic rx_seen;
  logic ovf_seen;
  logic fault_seen;
  logic master_on;
  logic slave_on;
  logic slave_active;
  logic idle;
  logic m_tick;
  logic m_edge;
  logic s_lead;
  logic s_trail;
  logic s_edge;
  logic edge_event;
  logic sample_edge;
  logic last_edge;
  logic m_start;
  logic s_start;
  logic fault_event;
  logic abort;
  logic load_now;
  logic rx_bit;
  logic [DATA_BITS-1:0] shifted;
  logic [DATA_BITS-1:0] load_value;

  ////////////////////////////////////////////////////////////////////////
  // Mode and event decode

  assign master_on = enable && master_select;
  assign slave_on = enable && !master_select;
  assign slave_active = slave_on && !slave_select_n;
  assign idle = (state == XFER_IDLE);

  spi_rate_gen rate_gen (
    .clk(clk),
    .reset(reset),
    .run(master_on),
    .rate({rate_sel_hi, rate_sel_lo}),
    .tick(m_tick)
  );

  // Slave clock edges are judged on each bus cycle, independent of the rate
  assign s_lead = slave_active && (serial_clock_pin_in != sck_prev)
    && (serial_clock_pin_in != clock_polarity);
  assign s_trail = slave_active && (serial_clock_pin_in != sck_prev)
    && (serial_clock_pin_in == clock_polarity);

  assign m_edge = master_on && !idle && m_tick;
  // With phase set the first clock edge both starts and shifts
  assign s_edge = (s_lead || s_trail)
    && (!idle || (clock_phase_select && s_lead));
  assign edge_event = m_edge || s_edge;

  // Phase clear samples on even edges, phase set on odd edges
  assign sample_edge = clock_phase_select ? edge_count[0] : !edge_count[0];
  assign last_edge = edge_event && (edge_count == LAST_EDGE);

  assign m_start = master_on && idle && shifter_loaded && slave_select_n;
  assign s_start = slave_on && idle && !clock_phase_select
    && select_prev && !slave_select_n;

  assign fault_event = master_on && !slave_select_n;
  assign abort = !idle && (!enable || fault_event || (!master_select && slave_select_n));

  assign rx_bit = master_select ? miso_in : mosi_in;
  assign shifted = {shifter[DATA_BITS-2:0], rx_bit};

  // Buffer reaches the shifter only between transfers
  assign load_now = idle && !shifter_loaded && !s_edge && !s_start
    && (data_write || tx_full);
  assign load_value = tx_full ? tx_buffer : tx_data;

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencing

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= XFER_IDLE;
      edge_count <= '0;
    end
    else if (abort || last_edge)
    begin
      state <= XFER_IDLE;
      edge_count <= '0;
    end
    else if (m_start || s_start)
    begin
      state <= XFER_SHIFT;
      edge_count <= '0;
    end
    else if (edge_event)
    begin
      state <= XFER_SHIFT;
      edge_count <= edge_count + CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register and serial output bit

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      shifter <= DATA_RESET;
      shifter_loaded <= 1'b0;
      out_bit <= 1'b0;
    end
    else
    begin
      if (load_now)
      begin
        shifter <= load_value;
        shifter_loaded <= 1'b1;
        out_bit <= load_value[DATA_BITS-1];
      end
      else if (m_start || s_start)
        out_bit <= shifter[DATA_BITS-1];
      else if (edge_event && sample_edge)
        shifter <= shifted;
      else if (edge_event)
        out_bit <= shifter[DATA_BITS-1];
      if (abort || last_edge)
        shifter_loaded <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial clock generation and pin history

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sck_level <= 1'b0;
      sck_prev <= 1'b0;
      select_prev <= 1'b1;
    end
    else
    begin
      sck_prev <= serial_clock_pin_in;
      select_prev <= slave_select_n;
      if (idle || abort)
        sck_level <= clock_polarity;
      else if (m_edge)
        sck_level <= !sck_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit holding register

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_buffer <= DATA_RESET;
      tx_full <= !TX_EMPTY_RESET;
    end
    else if (data_write)
    begin
      tx_buffer <= tx_data;
      tx_full <= !(load_now && !tx_full);
    end
    else if (load_now)
      tx_full <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive holding register and flags

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      serial_data_reg <= DATA_RESET;
      rx_full_flag <= RX_FULL_RESET;
      rx_seen <= 1'b0;
      overflow_flag <= 1'b0;
      ovf_seen <= 1'b0;
      mode_fault_flag <= 1'b0;
      fault_seen <= 1'b0;
    end
    else
    begin
      if (status_read)
      begin
        rx_seen <= rx_full_flag;
        ovf_seen <= overflow_flag;
        fault_seen <= mode_fault_flag;
      end
      else if (data_read)
      begin
        rx_seen <= 1'b0;
        ovf_seen <= 1'b0;
        fault_seen <= 1'b0;
      end
      if (data_read && !status_read && rx_seen)
        rx_full_flag <= 1'b0;
      if (data_read && !status_read && ovf_seen)
        overflow_flag <= 1'b0;
      if (data_read && !status_read && fault_seen)
        mode_fault_flag <= 1'b0;
      if (last_edge && rx_full_flag && !(data_read && rx_seen))
        overflow_flag <= 1'b1;
      else if (last_edge)
      begin
        serial_data_reg <= sample_edge ? shifted : shifter;
        rx_full_flag <= 1'b1;
      end
      if (fault_event)
        mode_fault_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tx_empty_flag = !tx_full;
  assign busy = !idle;

  assign rx_full_irq = rx_irq_enable && rx_full_flag;
  assign tx_empty_irq = tx_irq_enable && !tx_full;
  assign error_irq = err_irq_enable && (overflow_flag || mode_fault_flag);

  assign serial_clock_pin_out = sck_level;
  assign serial_clock_pin_oe = master_on;
  assign mosi_out = out_bit;
  assign mosi_oe = master_on;
  assign miso_out = out_bit;
  assign miso_oe = slave_active;

endmodule // spi_master_slave_core
`default_nettype wire

/* File: spi_core_pkg.sv */
package spi_core_pkg;

  // Transfer shape
  localparam int WORD_BITS = 8;
  localparam int EDGES_PER_BIT = 2;

  // Master half-period lengths in bus cycles for the four rate codes
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // Rate codes
  localparam logic [1:0] RATE_DIV2 = 2'h0;
  localparam logic [1:0] RATE_DIV8 = 2'h1;
  localparam logic [1:0] RATE_DIV32 = 2'h2;
  localparam logic [1:0] RATE_DIV128 = 2'h3;

  // Reset values
  localparam logic [WORD_BITS-1:0] DATA_RESET = 8'h00;
  localparam logic TX_EMPTY_RESET = 1'b1;
  localparam logic RX_FULL_RESET = 1'b0;

  typedef enum logic {
    XFER_IDLE = 1'b0,
    XFER_SHIFT = 1'b1
  } xfer_state_t;

endpackage

/* File: spi_rate_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_rate_gen
  import spi_core_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [1:0] rate,
  // Half-period strobe
  output logic tick
);

  logic [6:0] count;
  logic [6:0] half_len;

  always_comb
  begin
    unique case (rate)
      RATE_DIV2: half_len = HALF_DIV2;
      RATE_DIV8: half_len = HALF_DIV8;
      RATE_DIV32: half_len = HALF_DIV32;
      RATE_DIV128: half_len = HALF_DIV128;
    endcase
  end

  // Free-running while the master is enabled
  assign tick = run && (count >= half_len - 7'h01);

  always_ff @(posedge clk)
  begin
    if (reset || !run || tick)
      count <= 7'h00;
    else
      count <= count + 7'h01;
  end

endmodule // spi_rate_gen
`default_nettype wire

/* File: spi_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_core_monitor
  import spi_core_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic master_select,
  input wire logic data_write,
  input wire logic data_read,
  input wire logic slave_select_n,
  input wire logic tx_empty_flag,
  input wire logic rx_full_flag,
  input wire logic overflow_flag,
  input wire logic mode_fault_flag,
  input wire logic busy,
  input wire logic serial_clock_pin_oe,
  input wire logic miso_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_reset_flags:
    assert property (disable iff (1'b0) reset |=> tx_empty_flag && !rx_full_flag)
    else $error("reset flags wrong");
  chk_master_pins:
    assert property (serial_clock_pin_oe == (enable && master_select))
    else $error("clock pin drive wrong");
  chk_miso_drive:
    assert property (miso_oe == (enable && !master_select && !slave_select_n))
    else $error("miso drive wrong");
  chk_slave_no_start:
    assert property ((!master_select && slave_select_n) [*4] |-> !busy)
    else $error("slave started alone");
  chk_write_empty:
    assert property (data_write && busy |=> !tx_empty_flag)
    else $error("empty flag kept");
  chk_master_end:
    assert property ($fell(busy) && master_select && !mode_fault_flag
      && !$past(rx_full_flag) |-> rx_full_flag)
    else $error("end without full");
  chk_rx_hold:
    assert property (rx_full_flag && !data_read |=> rx_full_flag)
    else $error("full flag lost");
  chk_overflow_cause:
    assert property ($rose(overflow_flag) |-> rx_full_flag)
    else $error("overflow without full");
endmodule // spi_core_monitor

bind spi_master_slave_core spi_core_monitor i_spi_core_monitor (.clk, .reset, .enable,
  .master_select, .data_write, .data_read, .slave_select_n, .tx_empty_flag, .rx_full_flag,
  .overflow_flag, .mode_fault_flag, .busy, .serial_clock_pin_oe, .miso_oe);
`default_nettype wire

/* File: spi_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  // Serial lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // Byte exchanged
  input wire logic [7:0] reply,
  output logic [7:0] shifter
);
  logic cap;
  initial shifter = 8'h00;
  // Load at select, capture on rising, shift on falling
  always @(negedge sel_n) shifter = reply;
  always @(posedge sck) cap = mosi;
  always @(negedge sck) if (!sel_n) shifter = {shifter[6:0], cap};
  // Released line shows the inverse of the top shifter bit
  assign miso = sel_n ? ~shifter[7] : shifter[7];
endmodule // spi_slave_model
`default_nettype wire

/* File: tb_spi_master_slave_core.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_spi_master_slave_core;
  import spi_core_pkg::*;
  logic clk = 1'b0, reset = 1'b1, enable = 1'b0, master_select = 1'b0;
  logic clock_polarity = 1'b0, clock_phase_select = 1'b0, rate_sel_hi = 1'b0, rate_sel_lo = 1'b0;
  logic rx_irq_enable = 1'b1, tx_irq_enable = 1'b1, err_irq_enable = 1'b1;
  logic data_write = 1'b0, status_read = 1'b0, data_read = 1'b0, slave_select_n = 1'b1;
  logic [7:0] tx_data = 8'h00, reply = 8'h00, serial_data_reg, part_rx;
  logic tx_empty_flag, rx_full_flag, overflow_flag, mode_fault_flag, busy, rx_full_irq;
  logic tx_empty_irq, error_irq, serial_clock_pin_out, serial_clock_pin_oe, mosi_out, mosi_oe;
  logic miso_in, miso_out, miso_oe, tb_sck = 1'b0, tb_mosi = 1'b0, part_sel_n = 1'b1;
  wire logic serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : tb_sck;
  wire logic mosi_in = mosi_oe ? mosi_out : tb_mosi;
  int num_errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  spi_master_slave_core i_spi_master_slave_core (.clk, .reset, .enable, .master_select,
    .clock_polarity, .clock_phase_select, .rate_sel_hi, .rate_sel_lo, .rx_irq_enable,
    .tx_irq_enable, .err_irq_enable, .tx_data, .data_write, .status_read, .data_read,
    .serial_data_reg, .tx_empty_flag, .rx_full_flag, .overflow_flag, .mode_fault_flag, .busy,
    .rx_full_irq, .tx_empty_irq, .error_irq, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
    .slave_select_n);
  spi_slave_model i_spi_slave_model (.sck(serial_clock_pin_in), .mosi(mosi_in),
    .sel_n(part_sel_n), .miso(miso_in), .reply, .shifter(part_rx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic write(input logic [7:0] d);
    tx_data = d;
    data_write = 1'b1;
    @(negedge clk);
    data_write = 1'b0;
    @(negedge clk);
  endtask
  task clear_flags;
    status_read = 1'b1;
    @(negedge clk);
    status_read = 1'b0;
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_rx;
    int n = 0;
    while (!rx_full_flag && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (!rx_full_flag) num_errors++;
  endtask
  task automatic master_xfer(input logic [1:0] r, input logic [7:0] d);
    int n = 0, cnt = 0, gap = 0;
    logic prev = 1'b0;
    {rate_sel_hi, rate_sel_lo} = r;
    reply = ~d;
    part_sel_n = 1'b0;
    write(d);
    while (!rx_full_flag && n < 3000)
    begin
      @(negedge clk);
      n++;
      cnt++;
      if (serial_clock_pin_in !== prev)
      begin
        gap = cnt;
        cnt = 0;
      end
      prev = serial_clock_pin_in;
    end
    check(8'(gap), 8'(1 << (2 * r)));
    check(serial_data_reg, ~d);
    check(part_rx, d);
    check(rx_full_irq, 1'b1);
    part_sel_n = 1'b1;
    clear_flags;
    check(rx_full_flag, 1'b0);
  endtask
  task automatic queued;
    {rate_sel_hi, rate_sel_lo} = RATE_DIV2;
    reply = 8'h5A;
    part_sel_n = 1'b0;
    write(8'hC3);
    check(tx_empty_flag, 1'b1);
    check(tx_empty_irq, 1'b1);
    @(negedge clk);
    write(8'h3C);
    check(tx_empty_flag, 1'b0);
    check(tx_empty_irq, 1'b0);
    wait_rx;
    check(serial_data_reg, 8'h5A);
    clear_flags;
    wait_rx;
    check(part_rx, 8'h3C);
    check(serial_data_reg, 8'hC3);
    part_sel_n = 1'b1;
    clear_flags;
  endtask
  task automatic fault;
    slave_select_n = 1'b0;
    repeat (4) @(negedge clk);
    check(mode_fault_flag, 1'b1);
    check(error_irq, 1'b1);
    slave_select_n = 1'b1;
    clear_flags;
    check(mode_fault_flag, 1'b0);
  endtask
  task automatic slave_xfer(input logic [7:0] d, input logic [7:0] mid, input logic [7:0] exp);
    logic [7:0] got;
    slave_select_n = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      if (!clock_phase_select) tb_mosi = d[i];
      repeat (2) @(negedge clk);
      tb_sck = !clock_polarity;
      if (clock_phase_select) tb_mosi = d[i];
      else got[i] = miso_out;
      if (i == 4 && mid !== 8'h00) write(mid);
      repeat (2) @(negedge clk);
      if (clock_phase_select) got[i] = miso_out;
      tb_sck = clock_polarity;
    end
    repeat (2) @(negedge clk);
    slave_select_n = 1'b1;
    tb_mosi = ~tb_mosi;
    repeat (3) @(negedge clk);
    check(got, exp);
  endtask
  task automatic slave_mode;
    enable = 1'b0;
    master_select = 1'b0;
    @(negedge clk);
    enable = 1'b1;
    write(8'h3C);
    slave_xfer(8'h96, 8'hC3, 8'h3C);
    check(serial_data_reg, 8'h96);
    check(rx_full_flag, 1'b1);
    slave_xfer(8'h5A, 8'h00, 8'hC3);
    check(overflow_flag, 1'b1);
    check(serial_data_reg, 8'h96);
    slave_xfer(8'h11, 8'h00, 8'h5A);
    clear_flags;
    check(overflow_flag, 1'b0);
    enable = 1'b0;
    clock_phase_select = 1'b1;
    clock_polarity = 1'b1;
    tb_sck = 1'b1;
    @(negedge clk);
    enable = 1'b1;
    write(8'hE7);
    slave_xfer(8'h69, 8'h00, 8'hE7);
    check(serial_data_reg, 8'h69);
    clear_flags;
    check(rx_full_flag, 1'b0);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    check(tx_empty_flag, 1'b1);
    check(rx_full_flag, 1'b0);
    enable = 1'b1;
    master_select = 1'b1;
    @(negedge clk);
    for (int r = 0; r < 4; r++) master_xfer(2'(r), 8'hA5 ^ 8'(r));
    queued;
    fault;
    slave_mode;
    results;
  end
  initial
  begin
    #200000;
    num_errors++;
    results;
  end
endmodule // tb_spi_master_slave_core
`default_nettype wire
